// ==== hdl/rgbcd_dimmer.sv ====
`timescale 1ns/1ns
module rgbcd_dimmer #(
   parameter int STEP_UNIT_CYCLES = rgbcd_pkg::STEP_UNIT_CYCLES_DEF
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Commands
   input wire logic load_i,
   input wire logic [4:0] load_step_i,
   input wire logic run_i,
   input wire logic run_up_i,
   input wire logic [4:0] target_i,
   input wire logic [4:0] duration_i,
   // State
   output logic [4:0] step_o,
   output logic busy_o
);

   rgbcd_pkg::rgbcd_dim_state_t state_reg, state_next;
   logic [4:0] pos_reg, pos_next;
   logic up_reg, up_next;
   logic wrap_reg, wrap_next;
   logic [4:0] tgt_reg, tgt_next;
   logic [4:0] dur_reg, dur_next;
   logic [31:0] unit_reg, unit_next;
   logic [4:0] mult_reg, mult_next;

   // ************************************************
   // Step timer
   // ************************************************
   wire unit_end = (unit_reg == 32'(STEP_UNIT_CYCLES - 1));
   wire step_tick = unit_end && (mult_reg == dur_reg - 5'h01); // [R16]
   wire at_target = !wrap_reg && (pos_reg == tgt_reg);
   wire [4:0] dur_eff = (duration_i == 5'h00) ? rgbcd_pkg::DUR_MIN : duration_i;
   wire wrap_start = run_up_i ? (target_i < pos_reg) : (target_i > pos_reg);

   always_comb begin
      state_next = state_reg;
      pos_next = pos_reg;
      up_next = up_reg;
      wrap_next = wrap_reg;
      tgt_next = tgt_reg;
      dur_next = dur_reg;
      unit_next = unit_end ? 32'h0 : unit_reg + 32'h1;
      mult_next = unit_end ? mult_reg + 5'h01 : mult_reg;
      if (step_tick) begin
         mult_next = 5'h00;
      end
      if (load_i) begin
         pos_next = load_step_i; // [R6]
         state_next = rgbcd_pkg::DM_IDLE;
      end else if (run_i) begin
         state_next = rgbcd_pkg::DM_RUN; // [R10]
         up_next = run_up_i;
         tgt_next = target_i;
         wrap_next = wrap_start; // [R17]
         dur_next = dur_eff;
         unit_next = 32'h0;
         mult_next = 5'h00;
      end else begin
         case (state_reg)
            rgbcd_pkg::DM_RUN: begin
               if (at_target) begin
                  state_next = rgbcd_pkg::DM_IDLE;
               end else if (step_tick && wrap_reg && up_reg) begin
                  pos_next = (pos_reg == rgbcd_pkg::STEP_MAX) ? rgbcd_pkg::STEP_ZERO
                                                             : pos_reg + 5'h01; // [R17]
                  wrap_next = (pos_reg != rgbcd_pkg::STEP_MAX);
               end else if (step_tick && wrap_reg) begin
                  pos_next = (pos_reg == rgbcd_pkg::STEP_ZERO) ? rgbcd_pkg::STEP_MAX
                                                              : pos_reg - 5'h01; // [R17]
                  wrap_next = (pos_reg != rgbcd_pkg::STEP_ZERO);
               end else if (step_tick) begin
                  pos_next = (pos_reg < tgt_reg) ? pos_reg + 5'h01 : pos_reg - 5'h01; // [R16]
               end
            end
            default: begin
               state_next = rgbcd_pkg::DM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= rgbcd_pkg::DM_IDLE;
         pos_reg <= rgbcd_pkg::STEP_ZERO;
         up_reg <= 1'b0;
         wrap_reg <= 1'b0;
         tgt_reg <= rgbcd_pkg::STEP_ZERO;
         dur_reg <= rgbcd_pkg::DUR_MIN;
         unit_reg <= 32'h0;
         mult_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         pos_reg <= pos_next;
         up_reg <= up_next;
         wrap_reg <= wrap_next;
         tgt_reg <= tgt_next;
         dur_reg <= dur_next;
         unit_reg <= unit_next;
         mult_reg <= mult_next;
      end
   end

   assign step_o = pos_reg;
   assign busy_o = (state_reg == rgbcd_pkg::DM_RUN);

   a_step_move: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R16]
      (busy_o && !wrap_reg && !at_target && !step_tick && !load_i && !run_i)
      |=> $stable(pos_reg))
      else $error("Step moved between ticks");

endmodule : rgbcd_dimmer

// ==== hdl/rgbcd_i2c_target.sv ====
`timescale 1ns/1ns
module rgbcd_i2c_target (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Synchronised link levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Data line drive
   output logic sda_oe_n_o,
   // Received command
   output logic cmd_valid_o,
   output logic [7:0] cmd_byte_o
);

   // ************************************************
   // Edge detection
   // ************************************************
   logic scl_d_reg;
   logic sda_d_reg;
   rgbcd_pkg::rgbcd_tgt_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic oe_n_reg, oe_n_next;
   logic valid_reg, valid_next;

   wire scl_rise = scl_i && !scl_d_reg;
   wire scl_fall = !scl_i && scl_d_reg;
   wire start_seen = scl_i && scl_d_reg && !sda_i && sda_d_reg;
   wire stop_seen = scl_i && scl_d_reg && sda_i && !sda_d_reg;
   wire byte_done = scl_fall && (cnt_reg == rgbcd_pkg::BITS_PER_BYTE);
   wire addr_hit = (shift_reg[7:1] == rgbcd_pkg::TARGET_ADDR) && !shift_reg[0];

   // ************************************************
   // Frame sequencer
   // ************************************************
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      oe_n_next = oe_n_reg;
      valid_next = 1'b0;
      if (start_seen) begin
         state_next = rgbcd_pkg::TS_ADDR;
         cnt_next = 4'h0;
         oe_n_next = 1'b1;
      end else if (stop_seen) begin
         state_next = rgbcd_pkg::TS_IDLE;
         oe_n_next = 1'b1;
      end else begin
         case (state_reg)
            rgbcd_pkg::TS_ADDR, rgbcd_pkg::TS_DATA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_i};
                  cnt_next = cnt_reg + 4'h1;
               end
               if (byte_done && state_reg == rgbcd_pkg::TS_ADDR) begin
                  state_next = addr_hit ? rgbcd_pkg::TS_ADDR_ACK : rgbcd_pkg::TS_SKIP; // [R1] [R2] [R19]
                  oe_n_next = !addr_hit;
               end else if (byte_done) begin
                  state_next = rgbcd_pkg::TS_DATA_ACK;
                  oe_n_next = 1'b0;
               end
            end
            rgbcd_pkg::TS_ADDR_ACK: begin
               if (scl_fall) begin
                  state_next = rgbcd_pkg::TS_DATA;
                  cnt_next = 4'h0;
                  oe_n_next = 1'b1;
               end
            end
            rgbcd_pkg::TS_DATA_ACK: begin
               valid_next = scl_rise; // [R18]
               if (scl_fall) begin
                  state_next = rgbcd_pkg::TS_SKIP; // [R3]
                  oe_n_next = 1'b1;
               end
            end
            default: begin
               oe_n_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         state_reg <= rgbcd_pkg::TS_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         oe_n_reg <= 1'b1;
         valid_reg <= 1'b0;
      end else begin
         scl_d_reg <= scl_i;
         sda_d_reg <= sda_i;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         oe_n_reg <= oe_n_next;
         valid_reg <= valid_next;
      end
   end

   assign sda_oe_n_o = oe_n_reg;
   assign cmd_valid_o = valid_reg;
   assign cmd_byte_o = shift_reg;

   // ************************************************
   // Checks
   // ************************************************
   a_foreign_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R19]
      (state_reg == rgbcd_pkg::TS_ADDR && byte_done && !addr_hit && !start_seen && !stop_seen)
      |=> (oe_n_reg && state_reg == rgbcd_pkg::TS_SKIP))
      else $error("Foreign address acknowledged");

endmodule : rgbcd_i2c_target

// ==== hdl/rgbcd_pkg.sv ====
package rgbcd_pkg;

   // ************************************************
   // Clocks and timebase
   // ************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int TIMEBASE_HZ = 1_000_000;
   localparam int TIMEBASE_DIV = CLK_HZ / TIMEBASE_HZ;
   localparam logic [3:0] TIMEBASE_LAST = 4'(TIMEBASE_DIV - 1);
   localparam logic [3:0] PWM_TICK_LAST = 4'he;
   localparam int STEP_UNIT_MS = 8;
   localparam int STEP_UNIT_CYCLES_DEF = STEP_UNIT_MS * (CLK_HZ / 1000);

   // ************************************************
   // Link and command byte
   // ************************************************
   localparam logic [6:0] TARGET_ADDR = 7'h38;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int FUNC_MSB = 7;
   localparam int FUNC_LSB = 5;
   localparam int VAL_MSB = 4;
   localparam int VAL_LSB = 0;

   typedef enum logic [2:0] {
      FN_SHUTDOWN = 3'h0,
      FN_PEAK = 3'h1,
      FN_DUTY1 = 3'h2,
      FN_DUTY2 = 3'h3,
      FN_DUTY3 = 3'h4,
      FN_RISE = 3'h5,
      FN_FALL = 3'h6,
      FN_TIME_RUN = 3'h7
   } rgbcd_func_t;

   // ************************************************
   // Step and duty codes
   // ************************************************
   localparam logic [4:0] STEP_ZERO = 5'h00;
   localparam logic [4:0] STEP_TOP = 5'h1e;
   localparam logic [4:0] STEP_MAX = 5'h1f;
   localparam logic [4:0] DUTY_OFF = 5'h00;
   localparam logic [4:0] DUTY_FULL = 5'h1f;
   localparam logic [4:0] DUR_MIN = 5'h01;

   typedef enum logic [2:0] {
      TS_IDLE = 3'h0,
      TS_ADDR = 3'h1,
      TS_ADDR_ACK = 3'h2,
      TS_DATA = 3'h3,
      TS_DATA_ACK = 3'h4,
      TS_SKIP = 3'h5
   } rgbcd_tgt_state_t;

   typedef enum logic [1:0] {
      DM_IDLE = 2'h0,
      DM_RUN = 2'h1
   } rgbcd_dim_state_t;

   function automatic logic [4:0] rgbcd_eff_step(input logic [4:0] s);
      return (s == STEP_MAX) ? STEP_TOP : s;
   endfunction : rgbcd_eff_step

endpackage : rgbcd_pkg

// ==== hdl/rgbcd_top.sv ====
`timescale 1ns/1ns
// Overview of operation
// [R1] Answer only the fixed seven-bit target address
// [R2] Controller only writes; reads get no acknowledge
// [R3] One frame: address byte then one command
// [R4] Top three bits select one of eight functions
// [R5] Code zero shuts down, all LEDs off
// [R6] Peak step shared by all, no dimming
// [R7] Three independent five-bit duties, 32 steps
// [R8] Store upward dimming end step
// [R9] Store downward dimming end step
// [R10] Top code loads step time, starts dimming
// [R11] Step zero forces LED current off
// [R12] Step 31 behaves like step 30
// [R13] Nonzero step sets current via step code
// [R14] Overvoltage halts converter, resumes below low limit
// [R15] Duty zero off, full on, proportional between
// [R16] Steps equal distance, each lasts step time
// [R17] Wrong-side target wraps through extreme first
// [R18] New level takes effect on acknowledge
// [R19] Foreign address ignored, nothing changes
// [R20] All settings zero after reset; dir_up_reg resets to 1 (upward)
module rgbcd_top #(
   parameter int STEP_UNIT_CYCLES = rgbcd_pkg::STEP_UNIT_CYCLES_DEF
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Two-wire link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Output voltage comparators
   input wire logic vout_above_high_i,
   input wire logic vout_below_low_i,
   // LED drive
   output logic led1_on_o,
   output logic led2_on_o,
   output logic led3_on_o,
   output logic [4:0] led_peak_current_o,
   // Status
   output logic converter_en_o,
   output logic dimming_o
);

   // ************************************************
   // Input synchronisers
   // ************************************************
   logic scl_meta_reg;
   logic scl_sync_reg;
   logic sda_meta_reg;
   logic sda_sync_reg;
   logic hi_meta_reg;
   logic hi_sync_reg;
   logic lo_meta_reg;
   logic lo_sync_reg;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         hi_meta_reg <= 1'b0;
         hi_sync_reg <= 1'b0;
         lo_meta_reg <= 1'b0;
         lo_sync_reg <= 1'b0;
      end else begin
         scl_meta_reg <= scl_i;
         scl_sync_reg <= scl_meta_reg;
         sda_meta_reg <= sda_i;
         sda_sync_reg <= sda_meta_reg;
         hi_meta_reg <= vout_above_high_i;
         hi_sync_reg <= hi_meta_reg;
         lo_meta_reg <= vout_below_low_i;
         lo_sync_reg <= lo_meta_reg;
      end
   end

   // ************************************************
   // Link target
   // ************************************************
   logic tgt_oe_n;
   logic cmd_valid;
   logic [7:0] cmd_byte;

   rgbcd_i2c_target u_target (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .scl_i(scl_sync_reg),
      .sda_i(sda_sync_reg),
      .sda_oe_n_o(tgt_oe_n),
      .cmd_valid_o(cmd_valid),
      .cmd_byte_o(cmd_byte)
   );

   // ************************************************
   // Command decode
   // ************************************************
   wire rgbcd_pkg::rgbcd_func_t cmd_func =
      rgbcd_pkg::rgbcd_func_t'(cmd_byte[rgbcd_pkg::FUNC_MSB:rgbcd_pkg::FUNC_LSB]); // [R4]
   wire [4:0] cmd_val = cmd_byte[rgbcd_pkg::VAL_MSB:rgbcd_pkg::VAL_LSB];
   wire wr_shutdown = cmd_valid && (cmd_func == rgbcd_pkg::FN_SHUTDOWN); // [R4]
   wire wr_peak = cmd_valid && (cmd_func == rgbcd_pkg::FN_PEAK);
   wire wr_duty1 = cmd_valid && (cmd_func == rgbcd_pkg::FN_DUTY1);
   wire wr_duty2 = cmd_valid && (cmd_func == rgbcd_pkg::FN_DUTY2);
   wire wr_duty3 = cmd_valid && (cmd_func == rgbcd_pkg::FN_DUTY3);
   wire wr_rise = cmd_valid && (cmd_func == rgbcd_pkg::FN_RISE);
   wire wr_fall = cmd_valid && (cmd_func == rgbcd_pkg::FN_FALL);
   wire wr_time = cmd_valid && (cmd_func == rgbcd_pkg::FN_TIME_RUN);
   wire wr_other = cmd_valid && !wr_shutdown;

   // ************************************************
   // Stored settings
   // ************************************************
   logic shutdown_reg;
   logic [4:0] led1_duty_reg;
   logic [4:0] led2_duty_reg;
   logic [4:0] led3_duty_reg;
   logic [4:0] rise_target_step_reg;
   logic [4:0] fall_target_step_reg;
   logic [4:0] dim_step_duration_reg;
   logic dir_up_reg;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         shutdown_reg <= 1'b0; // [R20]
         led1_duty_reg <= rgbcd_pkg::DUTY_OFF;
         led2_duty_reg <= rgbcd_pkg::DUTY_OFF;
         led3_duty_reg <= rgbcd_pkg::DUTY_OFF;
         rise_target_step_reg <= rgbcd_pkg::STEP_ZERO;
         fall_target_step_reg <= rgbcd_pkg::STEP_ZERO;
         dim_step_duration_reg <= 5'h00;
         dir_up_reg <= 1'b1;
      end else begin
         shutdown_reg <= wr_shutdown || (shutdown_reg && !wr_other); // [R5]
         led1_duty_reg <= wr_duty1 ? cmd_val : led1_duty_reg; // [R7]
         led2_duty_reg <= wr_duty2 ? cmd_val : led2_duty_reg; // [R7]
         led3_duty_reg <= wr_duty3 ? cmd_val : led3_duty_reg; // [R7]
         rise_target_step_reg <= wr_rise ? cmd_val : rise_target_step_reg; // [R8]
         fall_target_step_reg <= wr_fall ? cmd_val : fall_target_step_reg; // [R9]
         dim_step_duration_reg <= wr_time ? cmd_val : dim_step_duration_reg; // [R10]
         dir_up_reg <= wr_rise || (dir_up_reg && !wr_fall);
      end
   end

   // ************************************************
   // Gradual dimming
   // ************************************************
   logic [4:0] dim_step;
   logic dim_busy;
   wire [4:0] run_target = dir_up_reg ? rise_target_step_reg : fall_target_step_reg;

   rgbcd_dimmer #(
      .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
   ) u_dimmer (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .load_i(wr_peak),
      .load_step_i(cmd_val),
      .run_i(wr_time),
      .run_up_i(dir_up_reg),
      .target_i(run_target),
      .duration_i(cmd_val),
      .step_o(dim_step),
      .busy_o(dim_busy)
   );

   // ************************************************
   // Timebase and PWM phase
   // ************************************************
   logic [3:0] tb_cnt_reg;
   logic [3:0] pwm_div_reg;
   logic [4:0] pwm_phase_reg;
   wire tb_tick = (tb_cnt_reg == rgbcd_pkg::TIMEBASE_LAST);
   wire pwm_tick = tb_tick && (pwm_div_reg == rgbcd_pkg::PWM_TICK_LAST);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tb_cnt_reg <= 4'h0;
         pwm_div_reg <= 4'h0;
         pwm_phase_reg <= 5'h00;
      end else begin
         tb_cnt_reg <= tb_tick ? 4'h0 : tb_cnt_reg + 4'h1;
         pwm_div_reg <= pwm_tick ? 4'h0 : (tb_tick ? pwm_div_reg + 4'h1 : pwm_div_reg);
         pwm_phase_reg <= pwm_tick ? pwm_phase_reg + 5'h01 : pwm_phase_reg;
      end
   end

   function automatic logic rgbcd_duty_on(input logic [4:0] duty, input logic [4:0] phase);
      return (duty == rgbcd_pkg::DUTY_FULL) || (phase < duty); // [R15]
   endfunction : rgbcd_duty_on

   // ************************************************
   // LED drive and converter guard
   // ************************************************
   wire [4:0] eff_step = rgbcd_pkg::rgbcd_eff_step(dim_step); // [R12] [R13]
   wire drive_ok = !shutdown_reg && (eff_step != rgbcd_pkg::STEP_ZERO); // [R5] [R11]
   wire led1_next = drive_ok && rgbcd_duty_on(led1_duty_reg, pwm_phase_reg);
   wire led2_next = drive_ok && rgbcd_duty_on(led2_duty_reg, pwm_phase_reg);
   wire led3_next = drive_ok && rgbcd_duty_on(led3_duty_reg, pwm_phase_reg);
   wire [4:0] step_next = shutdown_reg ? rgbcd_pkg::STEP_ZERO : eff_step;

   logic guard_ok_reg;
   wire guard_ok_next = hi_sync_reg ? 1'b0 : (lo_sync_reg ? 1'b1 : guard_ok_reg); // [R14]

   logic led1_reg;
   logic led2_reg;
   logic led3_reg;
   logic [4:0] step_out_reg;
   logic conv_en_reg;
   logic dim_out_reg;
   logic sda_out_reg;
   logic oe_n_out_reg;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         guard_ok_reg <= 1'b1;
         led1_reg <= 1'b0;
         led2_reg <= 1'b0;
         led3_reg <= 1'b0;
         step_out_reg <= rgbcd_pkg::STEP_ZERO;
         conv_en_reg <= 1'b0;
         dim_out_reg <= 1'b0;
         sda_out_reg <= 1'b0;
         oe_n_out_reg <= 1'b1;
      end else begin
         guard_ok_reg <= guard_ok_next;
         led1_reg <= led1_next;
         led2_reg <= led2_next;
         led3_reg <= led3_next;
         step_out_reg <= step_next;
         conv_en_reg <= guard_ok_next && !shutdown_reg; // [R14]
         dim_out_reg <= dim_busy;
         sda_out_reg <= 1'b0;
         oe_n_out_reg <= tgt_oe_n;
      end
   end

   assign sda_o = sda_out_reg;
   assign sda_oe_n_o = oe_n_out_reg;
   assign led1_on_o = led1_reg;
   assign led2_on_o = led2_reg;
   assign led3_on_o = led3_reg;
   assign led_peak_current_o = step_out_reg;
   assign converter_en_o = conv_en_reg;
   assign dimming_o = dim_out_reg;

   // ************************************************
   // Checks
   // ************************************************
   a_shutdown_dark: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R5]
      shutdown_reg |=> (!led1_reg && !led2_reg && !led3_reg && step_out_reg == 5'h00))
      else $error("LED lit during shutdown");

   a_peak_direct: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R6]
      wr_peak |=> (!dim_busy && dim_step == $past(cmd_val)) ##1
      (step_out_reg == rgbcd_pkg::rgbcd_eff_step($past(cmd_val, 2))))
      else $error("Peak step not applied directly");

   a_duty_store: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R7]
      (wr_duty2 && !wr_duty1) |=> (led2_duty_reg == $past(cmd_val) && $stable(led1_duty_reg)))
      else $error("Duty write wrong");

   a_rise_target: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R8]
      wr_rise |=> (rise_target_step_reg == $past(cmd_val) && dir_up_reg))
      else $error("Upward target not stored");

   a_fall_target: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R9]
      wr_fall |=> (fall_target_step_reg == $past(cmd_val) && !dir_up_reg))
      else $error("Downward target not stored");

   a_dim_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R10]
      wr_time |=> (dim_busy && dim_step_duration_reg == $past(cmd_val)))
      else $error("Dimming did not start");

   a_zero_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R11]
      (step_out_reg == rgbcd_pkg::STEP_ZERO) |-> (!led1_reg && !led2_reg && !led3_reg))
      else $error("LED lit at step zero");

   a_top_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R12]
      (dim_step == rgbcd_pkg::STEP_MAX && !shutdown_reg) |=> (step_out_reg == rgbcd_pkg::STEP_TOP))
      else $error("Top step not folded");

   a_guard_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R14]
      hi_sync_reg |=> !conv_en_reg ##0 (!lo_sync_reg && !hi_sync_reg) [*2] |-> !conv_en_reg)
      else $error("Converter ran above limit");

   a_guard_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R14]
      hi_sync_reg |=> !conv_en_reg)
      else $error("Converter not stopped above limit");

   a_guard_resume: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R14]
      (lo_sync_reg && !hi_sync_reg && !shutdown_reg) |=> conv_en_reg)
      else $error("Converter did not resume");

   a_duty_full: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R15]
      (drive_ok && led3_duty_reg == rgbcd_pkg::DUTY_FULL) |=> led3_reg)
      else $error("Full duty not on");

   a_duty_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R15]
      (led1_duty_reg == rgbcd_pkg::DUTY_OFF) |=> !led1_reg)
      else $error("Zero duty lit");

endmodule : rgbcd_top

// ==== verification/rgbcd_ctrl_model.sv ====
`timescale 1ns/1ns
// ************************************************
// Link controller model
// ************************************************
module rgbcd_ctrl_model (
   // Clock
   input wire logic sys_clk_i,
   // Two-wire link
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   logic r;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic q();
      repeat (2) @(posedge sys_clk_i);
      #1;
   endtask : q
   task automatic bit_x(input logic b);
      q();
      sda_o = b;
      q();
      scl_o = 1'b1;
      q();
      r = sda_i;
      q();
      scl_o = 1'b0;
   endtask : bit_x
   // Address byte first, then the command byte repeated
   task automatic frame(input logic [7:0] a, input logic [7:0] c, input int n,
                        output logic [2:0] acked);
      logic [7:0] v;
      acked = 3'h0;
      q();
      sda_o = 1'b0;
      q();
      scl_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         v = (k == 0) ? a : c;
         for (int i = 7; i >= 0; i--) begin
            bit_x(v[i]);
         end
         bit_x(1'b1);
         acked[k] = !r;
         q();
      end
      sda_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_o = 1'b1;
      q();
   endtask : frame
endmodule : rgbcd_ctrl_model

// ==== verification/test_i2c_rgb_led_command_decoder.sv ====
`timescale 1ns/1ns
module test_i2c_rgb_led_command_decoder;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic hi = 1'b0;
   logic lo = 1'b0;
   logic scl, sda_m, sda_o, oe_n, led1, led2, led3, conv, dim, sda_w;
   logic [4:0] peak;
   logic [2:0] ak;
   int mismatches = 0;
   int check_count = 0;
   int n;
   assign sda_w = sda_m & (oe_n | sda_o);
   always #50 sys_clk_i = ~sys_clk_i;
   rgbcd_top #(.STEP_UNIT_CYCLES(20)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(oe_n), .vout_above_high_i(hi),
      .vout_below_low_i(lo), .led1_on_o(led1), .led2_on_o(led2), .led3_on_o(led3),
      .led_peak_current_o(peak), .converter_en_o(conv), .dimming_o(dim));
   rgbcd_ctrl_model model_u (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] c);
      model_u.frame(8'h70, c, 2, ak);
      check({5'h0, ak}, 8'h03);
      cyc(4);
   endtask : wr
   task automatic dim_wait(input int lo_n, input int hi_n);
      n = 0;
      while (dim === 1'b1 && n < 3000) begin
         cyc(1);
         n++;
      end
      check({7'h0, n >= lo_n && n <= hi_n}, 8'h01);
   endtask : dim_wait
   // ************************************************
   // Test sequence
   // ************************************************
   initial begin
      cyc(2);
      rst_n_i = 1'b1;
      cyc(4);
      check({dim, oe_n, led1, peak}, 8'h40);
      $display("reset test done");
      model_u.frame(8'h72, 8'h3a, 2, ak);
      check({5'h0, ak}, 8'h00);
      model_u.frame(8'h71, 8'h3a, 2, ak);
      check({5'h0, ak}, 8'h00);
      check({3'h0, peak}, 8'h00);
      model_u.frame(8'h70, 8'h3f, 3, ak);
      check({5'h0, ak}, 8'h03);
      cyc(4);
      check({dim, 2'h0, peak}, 8'h1e);
      $display("link test done");
      wr(8'h5f);
      wr(8'h60);
      wr(8'h90);
      check({6'h0, led1, led2}, 8'h02);
      n = 0;
      repeat (4800) begin
         cyc(1);
         n += led3;
      end
      check(8'((n + 75) / 150), 8'h10);
      wr(8'h9f);
      check({7'h0, led3}, 8'h01);
      wr(8'h20);
      check({2'h0, led1, peak}, 8'h00);
      wr(8'h3d);
      check({2'h0, led1, peak}, 8'h3d);
      wr(8'h1f);
      check({conv, led1, peak}, 8'h00);
      wr(8'h25);
      check({conv, led1, peak}, 8'h65);
      $display("output test done");
      wr(8'ha8);
      wr(8'he1);
      check({7'h0, dim}, 8'h01);
      dim_wait(35, 62);
      check({3'h0, peak}, 8'h08);
      wr(8'hca);
      wr(8'he2);
      dim_wait(1160, 1202);
      check({3'h0, peak}, 8'h0a);
      wr(8'ha3);
      wr(8'he1);
      dim_wait(470, 502);
      check({3'h0, peak}, 8'h03);
      $display("dimming test done");
      hi = 1'b1;
      cyc(6);
      check({7'h0, conv}, 8'h00);
      hi = 1'b0;
      cyc(6);
      check({7'h0, conv}, 8'h00);
      lo = 1'b1;
      cyc(6);
      check({7'h0, conv}, 8'h01);
      $display("guard test done");
      give_verdict();
   end
   initial begin
      cyc(30000);
      mismatches++;
      give_verdict();
   end
endmodule : test_i2c_rgb_led_command_decoder
